/* rtl/tcb_top.sv */
/*
 * Three-channel 32-bit timer block top: prescaler taps, chaining, block-wide sync start,
 * line direction per mode, per-channel interrupt, quadrature input feed and fault output.
 * Assumes all inputs are synchronous to sys_clk; the block's clock is enabled upstream
 * and pins are routed by the pin controllers before use.
 */
// Functional notes
// (RQ1) Three identical channels, each with its own 32-bit counter, programmed independently.
// (RQ2) Five internal taps: master clock by 2, 8, 32, 128, and slow clock.
// (RQ3) When slow clock drives the master clock, fifth tap equals the master clock.
// (RQ4) One block control write starts all three channels together.
// (RQ5) Block mode selects each external clock input, allowing channel chaining.
// (RQ6) Each channel has three external clocks, five internal clocks, two lines.
// (RQ7) Line A is input while measuring and output while generating.
// (RQ8) Line B is input while measuring, input or output while generating.
// (RQ9) Each channel drives its own programmable interrupt output.
// (RQ10) Enabled quadrature decoder filters and decodes A0, B0, A1 for channels.
// (RQ11) Fault output to the PWM unit comes from compare events.
// (RQ12) Software enables block clock and routes pins before use.
// (RQ13) Divided taps are one-cycle enables from a free-running prescaler.
`timescale 1ns/10ps
`default_nettype none
`include "tcb_map.svh"

module tcb_top
    import tcb_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Clock sources
    input wire logic slow_clk_tick,
    input wire logic master_clk_source_sel,
    input wire logic [2:0] ext_clk_pins,
    // Block-wide control
    input wire logic sync_start,
    input wire tcb_chain_t chain,
    input wire tcb_chan_cfg_t [2:0] cfg,
    input wire logic qdec_en,
    // Channel lines, output enable low while driving
    input wire logic [2:0] chan_line_a_in,
    output logic [2:0] chan_line_a_out,
    output logic [2:0] chan_line_a_oe_n,
    input wire logic [2:0] chan_line_b_in,
    output logic [2:0] chan_line_b_out,
    output logic [2:0] chan_line_b_oe_n,
    // Results
    output logic [2:0][`TCB_CNT_W-1:0] count,
    output logic [2:0] chan_irq,
    output logic fault,
    output logic [`TCB_CNT_W-1:0] qdec_position,
    output logic qdec_dir
);

    // Tap of a channel's clock select
    function automatic logic pick_clk(input logic [2:0] sel, input tcb_taps_t t,
                                      input logic [2:0] xc);
        case (sel)
            `TCB_CLKSEL_DIV2: pick_clk = t.div2;
            `TCB_CLKSEL_DIV8: pick_clk = t.div8;
            `TCB_CLKSEL_DIV32: pick_clk = t.div32;
            `TCB_CLKSEL_DIV128: pick_clk = t.div128;
            `TCB_CLKSEL_SLOW: pick_clk = t.slow;
            `TCB_CLKSEL_XC0: pick_clk = xc[0];
            `TCB_CLKSEL_XC1: pick_clk = xc[1];
            default: pick_clk = xc[2];
        endcase
    endfunction : pick_clk

    // Chaining mux: pin or another channel's line A
    function automatic logic chain_src(input logic [1:0] sel, input logic pin,
                                       input logic [2:0] line_a, input int k);
        case (sel)
            2'h0: chain_src = pin;
            2'h1: chain_src = line_a[(k + 1) % 3];
            2'h2: chain_src = line_a[(k + 2) % 3];
            default: chain_src = 1'b0;
        endcase
    endfunction : chain_src

    logic [`TCB_PRE_W-1:0] pre, next_pre;
    tcb_taps_t taps;
    logic [2:0] line_a, xc_level, xc_prev, next_xc_prev, xc_edge;
    logic [2:0][`TCB_CNT_W-1:0] next_count;
    logic [2:0] run, next_run, next_chan_irq;
    logic [2:0] cmp_hit;
    logic next_fault;
    logic [2:0] line_a_reg, next_line_a_reg;

    // Free-running prescaler [RQ13]
    always_comb
    begin
        next_pre = pre + `TCB_PRE_W'(1);
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pre <= 7'h00;
        else
            pre <= next_pre;
    end

    // Tap enables from the prescaler, fifth tap from the slow clock [RQ2] [RQ13]
    always_comb
    begin
        taps.div2 = (pre & `TCB_DIV2_MASK) == `TCB_DIV2_MASK;
        taps.div8 = (pre & `TCB_DIV8_MASK) == `TCB_DIV8_MASK;
        taps.div32 = (pre & `TCB_DIV32_MASK) == `TCB_DIV32_MASK;
        taps.div128 = (pre & `TCB_DIV128_MASK) == `TCB_DIV128_MASK;
        taps.slow = master_clk_source_sel ? slow_clk_tick : 1'b1; // [RQ3]
    end

    // Line A seen by chaining is the pin in capture, own drive in waveform
    always_comb
    begin
        for (int k = 0; k < 3; k++)
            line_a[k] = cfg[k].wave ? line_a_reg[k] : chan_line_a_in[k];
    end

    // External clock inputs of each channel, chained per block mode [RQ5] [RQ6]
    always_comb
    begin
        xc_level[0] = chain_src(chain.xc0_sel, ext_clk_pins[0], line_a, 0);
        xc_level[1] = chain_src(chain.xc1_sel, ext_clk_pins[1], line_a, 1);
        xc_level[2] = chain_src(chain.xc2_sel, ext_clk_pins[2], line_a, 2);
        next_xc_prev = xc_level;
        xc_edge = xc_level & ~xc_prev;
    end

    // Counters, run state, compare, interrupts, fault [RQ1] [RQ4] [RQ9] [RQ11]
    always_comb
    begin
        next_fault = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            next_run[k] = cfg[k].clk_en & (run[k] | sync_start); // [RQ4]
            next_count[k] = count[k];
            cmp_hit[k] = 1'b0;
            if (cfg[k].clk_en && sync_start)
                next_count[k] = `TCB_CNT_RST;
            else if (run[k] && pick_clk(cfg[k].clk_sel, taps, xc_level & xc_edge))
            begin
                next_count[k] = count[k] + `TCB_CNT_W'(1); // [RQ1]
                cmp_hit[k] = (count[k] + `TCB_CNT_W'(1)) == cfg[k].cmp;
            end
            next_chan_irq[k] = cmp_hit[k] & cfg[k].irq_en; // [RQ9]
            next_line_a_reg[k] = cmp_hit[k] ? ~line_a_reg[k] : line_a_reg[k];
            next_fault = next_fault | (cmp_hit[k] & cfg[k].fault_en); // [RQ11]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= '0;
            run <= 3'h0;
            chan_irq <= 3'h0;
            fault <= 1'b0;
            xc_prev <= 3'h0;
            line_a_reg <= 3'h0;
        end
        else
        begin
            count <= next_count;
            run <= next_run;
            chan_irq <= next_chan_irq;
            fault <= next_fault;
            xc_prev <= next_xc_prev;
            line_a_reg <= next_line_a_reg;
        end
    end

    // Line directions by mode [RQ7] [RQ8]
    always_comb
    begin
        for (int k = 0; k < 3; k++)
        begin
            chan_line_a_out[k] = line_a_reg[k];
            chan_line_a_oe_n[k] = ~cfg[k].wave; // [RQ7]
            chan_line_b_out[k] = line_a_reg[k];
            chan_line_b_oe_n[k] = ~(cfg[k].wave & cfg[k].b_is_out); // [RQ8]
        end
    end

    // Quadrature decoder: filter A0, B0, A1 then count phase steps [RQ10]
    logic [2:0] q_in, q_filt, next_q_filt, q_prev, next_q_prev;
    logic [2:0][1:0] q_cnt, next_q_cnt;
    logic [`TCB_CNT_W-1:0] next_qdec_position;
    logic next_qdec_dir;

    always_comb
    begin
        q_in = {chan_line_a_in[1], chan_line_b_in[0], chan_line_a_in[0]};
        next_q_filt = q_filt;
        next_q_cnt = q_cnt;
        for (int i = 0; i < 3; i++)
        begin
            if (q_in[i] == q_filt[i])
                next_q_cnt[i] = 2'h0;
            else if (q_cnt[i] == 2'(`TCB_QDEC_FILT))
            begin
                next_q_filt[i] = q_in[i];
                next_q_cnt[i] = 2'h0;
            end
            else
                next_q_cnt[i] = q_cnt[i] + 2'h1;
        end
        next_q_prev = q_filt;
        next_qdec_position = qdec_position;
        next_qdec_dir = qdec_dir;
        if (qdec_en && (q_filt[0] != q_prev[0]))
        begin
            next_qdec_dir = q_filt[0] ^ q_filt[1];
            next_qdec_position = (q_filt[0] ^ q_filt[1]) ? qdec_position + `TCB_CNT_W'(1)
                                                        : qdec_position - `TCB_CNT_W'(1);
        end
        if (qdec_en && q_filt[2] && !q_prev[2])
            next_qdec_position = `TCB_CNT_RST; // Index line clears position
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_filt <= 3'h0;
            q_cnt <= '0;
            q_prev <= 3'h0;
            qdec_position <= `TCB_CNT_RST;
            qdec_dir <= 1'b0;
        end
        else
        begin
            q_filt <= next_q_filt;
            q_cnt <= next_q_cnt;
            q_prev <= next_q_prev;
            qdec_position <= next_qdec_position;
            qdec_dir <= next_qdec_dir;
        end
    end

    // Divide-by-8 tap fires exactly every eighth cycle
    property p_div8;
        @(posedge sys_clk) disable iff (!rst_n)
        taps.div8 |=> !taps.div8 [*7] ##1 taps.div8;
    endproperty
    a_div8: assert property (p_div8) else $error("div8 tap spacing wrong"); // [RQ2]
    // Slow tap is master rate when slow clock drives master
    property p_slow;
        @(posedge sys_clk) disable iff (!rst_n)
        !master_clk_source_sel |-> taps.slow;
    endproperty
    a_slow: assert property (p_slow) else $error("slow tap not master rate"); // [RQ3]
    // Sync start runs enabled channels 0 and 1 and clears the count of channel 0
    property p_sync;
        @(posedge sys_clk) disable iff (!rst_n)
        (sync_start && cfg[0].clk_en && cfg[1].clk_en) |=> run[0] && run[1] && count[0] == 0;
    endproperty
    a_sync: assert property (p_sync) else $error("sync start missed"); // [RQ4]
    // Line A direction follows mode
    property p_line_a;
        @(posedge sys_clk) disable iff (!rst_n)
        chan_line_a_oe_n[0] == !cfg[0].wave;
    endproperty
    a_line_a: assert property (p_line_a) else $error("line A direction wrong"); // [RQ7]
    // Line B never driven while measuring
    property p_line_b;
        @(posedge sys_clk) disable iff (!rst_n)
        !cfg[1].wave |-> chan_line_b_oe_n[1];
    endproperty
    a_line_b: assert property (p_line_b) else $error("line B driven in capture"); // [RQ8]
    // Interrupt follows a compare hit by one cycle
    property p_irq;
        @(posedge sys_clk) disable iff (!rst_n)
        chan_irq[0] |-> $past(cmp_hit[0]) && $past(cfg[0].irq_en);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without compare"); // [RQ9]
    // Position stands still while decoder is off
    property p_qdec;
        @(posedge sys_clk) disable iff (!rst_n)
        !qdec_en |=> $stable(qdec_position);
    endproperty
    a_qdec: assert property (p_qdec) else $error("position moved while off"); // [RQ10]
    // Fault only after a compare hit on a channel with fault enabled
    property p_fault;
        @(posedge sys_clk) disable iff (!rst_n)
        fault |-> $past(|(cmp_hit & {cfg[2].fault_en, cfg[1].fault_en, cfg[0].fault_en}));
    endproperty
    a_fault: assert property (p_fault) else $error("fault without compare"); // [RQ11]
    // Stopped counter holds its value when not synced
    property p_count;
        @(posedge sys_clk) disable iff (!rst_n)
        !run[2] && !sync_start |=> $stable(count[2]);
    endproperty
    a_count: assert property (p_count) else $error("stopped counter moved"); // [RQ1]

endmodule : tcb_top
`default_nettype wire

/* shared/tcb_map.svh */
/*
 * Constants of the three-channel timer block top: prescaler taps, clock selects,
 * counter width and reset values.
 * Assumes inclusion by its bare name from the package and the design file.
 */
`ifndef TCB_MAP_SVH
`define TCB_MAP_SVH

`define TCB_NUM_CHAN 3
`define TCB_CNT_W 32
`define TCB_PRE_W 7
`define TCB_DIV2_MASK 7'h01
`define TCB_DIV8_MASK 7'h07
`define TCB_DIV32_MASK 7'h1F
`define TCB_DIV128_MASK 7'h7F
`define TCB_CLKSEL_DIV2 3'h0
`define TCB_CLKSEL_DIV8 3'h1
`define TCB_CLKSEL_DIV32 3'h2
`define TCB_CLKSEL_DIV128 3'h3
`define TCB_CLKSEL_SLOW 3'h4
`define TCB_CLKSEL_XC0 3'h5
`define TCB_CLKSEL_XC1 3'h6
`define TCB_CLKSEL_XC2 3'h7
`define TCB_CNT_RST 32'h0000_0000
`define TCB_QDEC_FILT 2

`endif

/* shared/tcb_pkg.sv */
/*
 * Types of the three-channel timer block top.
 * Assumes tcb_map.svh is on the include path.
 */
`include "tcb_map.svh"

package tcb_pkg;

    // Clock taps shared by all channels, one-cycle enables
    typedef struct packed {
        logic div2;
        logic div8;
        logic div32;
        logic div128;
        logic slow;
    } tcb_taps_t;

    // Per-channel control from the user side
    typedef struct packed {
        logic [2:0] clk_sel;
        logic clk_en;
        logic wave;
        logic b_is_out;
        logic [`TCB_CNT_W-1:0] cmp;
        logic irq_en;
        logic fault_en;
    } tcb_chan_cfg_t;

    // Block chaining choice for each external clock input
    typedef struct packed {
        logic [1:0] xc2_sel;
        logic [1:0] xc1_sel;
        logic [1:0] xc0_sel;
    } tcb_chain_t;

    // Channel run state
    typedef enum logic [1:0] {
        TCB_STOPPED = 2'b01,
        TCB_RUNNING = 2'b10
    } tcb_run_t;

endpackage : tcb_pkg

/* dv/tcb_far_end.sv */
/*
 * Far-side model: external clock pins and the PWM fault sink.
 * Assumes the block's sys_clk; pins change after the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none

module tcb_far_end
(
    // Clock and control
    input wire logic sys_clk,
    input wire logic pins_run,
    // Pins and fault
    output logic [2:0] ext_clk_pins,
    input wire logic fault,
    output var int fault_seen
);
    logic [2:0] phase = 3'h0;

    // Pins run with a period of 8 cycles and stay low while idle
    always @(negedge sys_clk)
    begin
        phase <= pins_run ? phase + 3'h1 : 3'h0;
    end
    assign ext_clk_pins = {3{phase[2]}};

    // Fault input counts every pulse it sees; one process owns the count
    int n_fault = 0;
    always @(posedge sys_clk)
    begin
        if (fault === 1'b1)
            n_fault <= n_fault + 1;
    end
    assign fault_seen = n_fault;
endmodule : tcb_far_end

`default_nettype wire

/* dv/tb.sv */
/*
 * Self-checking bench of the timer block top.
 * Assumes tcb_pkg and tcb_map.svh; inputs change at the falling edge.
 */
`timescale 1ns/10ps
`default_nettype none
`include "tcb_map.svh"

module tb;
    import tcb_pkg::*;
    logic sys_clk, rst_n, slow_clk_tick, master_clk_source_sel, sync_start, qdec_en;
    logic pins_run, fault, qdec_dir;
    logic [2:0] ext_clk_pins, a_in, b_in, a_out, a_oe_n, b_out, b_oe_n, chan_irq;
    tcb_chain_t chain;
    tcb_chan_cfg_t [2:0] cfg;
    logic [2:0][`TCB_CNT_W-1:0] count;
    logic [`TCB_CNT_W-1:0] qdec_position;
    int n_mismatch, checks_done, cycles, fault_seen;

    tcb_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .slow_clk_tick(slow_clk_tick),
        .master_clk_source_sel(master_clk_source_sel), .ext_clk_pins(ext_clk_pins),
        .sync_start(sync_start), .chain(chain), .cfg(cfg), .qdec_en(qdec_en),
        .chan_line_a_in(a_in), .chan_line_a_out(a_out), .chan_line_a_oe_n(a_oe_n),
        .chan_line_b_in(b_in), .chan_line_b_out(b_out), .chan_line_b_oe_n(b_oe_n),
        .count(count), .chan_irq(chan_irq), .fault(fault),
        .qdec_position(qdec_position), .qdec_dir(qdec_dir));
    tcb_far_end i_far (.sys_clk(sys_clk), .pins_run(pins_run),
        .ext_clk_pins(ext_clk_pins), .fault(fault), .fault_seen(fault_seen));

    // Clock and a ceiling on run length
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step

    task automatic start_all;
        sync_start = 1'b1;
        step(1);
        sync_start = 1'b0;
    endtask : start_all

    task automatic cfg_ch(input int ch, input logic [2:0] sel, input logic wave,
                          input logic [31:0] cmp, input logic ie);
        cfg[ch] = '{sel, 1'b1, wave, wave, cmp, ie, ie};
    endtask : cfg_ch

    // Count gained by one channel over n cycles
    task automatic delta(input int ch, input int n, input logic [31:0] exp);
        logic [31:0] c0;
        c0 = count[ch];
        step(n);
        chk(count[ch] - c0, exp);
    endtask : delta

    // Three taps at once; a second start clears every running count
    task automatic t_taps;
        logic [2:0][31:0] c0;
        cfg_ch(0, `TCB_CLKSEL_DIV2, 1'b0, 32'h0, 1'b0);
        cfg_ch(1, `TCB_CLKSEL_DIV8, 1'b0, 32'h0, 1'b0);
        cfg_ch(2, `TCB_CLKSEL_DIV128, 1'b0, 32'h0, 1'b0);
        start_all();
        step(40);
        start_all();
        chk(count[0], 32'h0);
        chk(count[1], 32'h0);
        chk(count[2], 32'h0);
        c0 = count;
        step(256);
        chk(count[0] - c0[0], 32'h80);
        chk(count[1] - c0[1], 32'h20);
        chk(count[2] - c0[2], 32'h2);
    endtask : t_taps

    // Fifth tap follows the master clock, then the slow ticks
    task automatic t_slow;
        logic [31:0] c0;
        cfg_ch(0, `TCB_CLKSEL_SLOW, 1'b0, 32'h0, 1'b0);
        start_all();
        delta(0, 64, 32'h40);
        master_clk_source_sel = 1'b1;
        step(2);
        c0 = count[0];
        repeat (16)
        begin
            slow_clk_tick = 1'b1;
            step(1);
            slow_clk_tick = 1'b0;
            step(3);
        end
        chk(count[0] - c0, 32'h10);
    endtask : t_slow

    // External pin clocks a channel; a tied-low select stops it
    task automatic t_ext;
        logic [31:0] c0;
        pins_run = 1'b1;
        cfg_ch(0, `TCB_CLKSEL_XC0, 1'b0, 32'h0, 1'b0);
        start_all();
        step(4);
        delta(0, 64, 32'h8);
        chain.xc0_sel = 2'h3;
        step(4);
        delta(0, 64, 32'h0);
        pins_run = 1'b0;
        // Line A of channel 1 in capture clocks channel 0 through the chain
        cfg_ch(1, `TCB_CLKSEL_DIV2, 1'b0, 32'h0, 1'b0);
        chain.xc0_sel = 2'h1;
        step(2);
        c0 = count[0];
        repeat (4)
        begin
            a_in[1] = 1'b1;
            step(2);
            a_in[1] = 1'b0;
            step(2);
        end
        chk(count[0] - c0, 32'h4);
    endtask : t_ext

    // Compare hit: line toggles, interrupt and fault only where enabled
    task automatic t_cmp;
        logic [2:0] a0, b0;
        logic [31:0] c2;
        int irqs, f0;
        cfg_ch(0, `TCB_CLKSEL_DIV2, 1'b1, 32'h5, 1'b1);
        cfg_ch(1, `TCB_CLKSEL_DIV2, 1'b1, 32'h5, 1'b0);
        cfg_ch(2, `TCB_CLKSEL_DIV2, 1'b1, 32'hFFFF_0000, 1'b0);
        cfg[2].b_is_out = 1'b0;
        step(1);
        chk(a_oe_n, 3'h0);
        chk(b_oe_n, 3'h4);
        a0 = a_out;
        b0 = b_out;
        f0 = fault_seen;
        irqs = 0;
        start_all();
        repeat (40)
        begin
            step(1);
            if (chan_irq === 3'b001)
                irqs++;
        end
        chk(irqs, 1);
        chk(fault_seen - f0, 1);
        chk(a_out, a0 ^ 3'h3);
        chk(b_out, b0 ^ 3'h3);
        cfg[0].wave = 1'b0;
        step(1);
        chk({a_oe_n[0], b_oe_n[0]}, 2'h3);
        // A disabled channel ignores the block start and stands still
        cfg[2].clk_en = 1'b0;
        step(1);
        c2 = count[2];
        start_all();
        chk(count[2], c2);
        delta(2, 16, 32'h0);
    endtask : t_cmp

    // Two forward quadrature steps, then the index line clears
    task automatic t_qdec;
        logic [31:0] p0;
        qdec_en = 1'b1;
        p0 = qdec_position;
        a_in[0] = 1'b1;
        step(8);
        b_in[0] = 1'b1;
        step(8);
        a_in[0] = 1'b0;
        step(8);
        chk(qdec_position - p0, 32'h2);
        chk(qdec_dir, 1'b1);
        // Line A rising while B is high is one step back
        a_in[0] = 1'b1;
        step(8);
        chk(qdec_position - p0, 32'h1);
        chk(qdec_dir, 1'b0);
        a_in[1] = 1'b1;
        step(8);
        chk(qdec_position, 32'h0);
    endtask : t_qdec

    task automatic complete_run;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // Reset, then each scenario; clock source set up before use
    initial
    begin
        {rst_n, slow_clk_tick, master_clk_source_sel, sync_start, qdec_en} = 5'h00;
        {pins_run, a_in, b_in} = 7'h00;
        chain = '0;
        cfg = '0;
        step(3);
        rst_n = 1'b1;
        step(1);
        t_taps();
        t_slow();
        t_ext();
        t_cmp();
        t_qdec();
        complete_run();
    end
endmodule : tb

`default_nettype wire
